// *** rtl/icb_pkg.sv ***
// Operation
// - External-direction mode counts each pulse on the chosen input, up to 5 kHz.
// - Direction input low counts up, high counts down.
// - Dual-input mode counts up on one input, down on the other.
// - Quadrature mode detects direction and steps two per full A/B period.
// - Over-frequency mode interrupts when measured frequency exceeds the reference.
// - Under-frequency mode interrupts when measured frequency falls below the reference.
// - Gate intervals of 0.01 s, 0.1 s and 1.0 s are selectable.
// - External-direction pulse comes from lines 1-4, direction from lines 5-8.
// - Four flag outputs carry handler-set states to the main program.
// - The current count is a signed 32-bit two's-complement value.
// - Counting modes interrupt when the count reaches the reference value.
// - Clear input high forces the count to zero.
// - The block runs only while activation is high, when gating is configured.
package icb_pkg;
    localparam int ICB_CLK_HZ = 40000000;
    localparam int ICB_MAX_PULSE_HZ = 5000;
    localparam int ICB_GATE0_MS = 10;
    localparam int ICB_GATE1_MS = 100;
    localparam int ICB_GATE2_MS = 1000;
    localparam int ICB_GATE0_CYC = ICB_CLK_HZ / 1000 * ICB_GATE0_MS;
    localparam int ICB_GATE1_CYC = ICB_CLK_HZ / 1000 * ICB_GATE1_MS;
    localparam int ICB_GATE2_CYC = ICB_CLK_HZ / 1000 * ICB_GATE2_MS;
    localparam int ICB_GATE0_MUL = 100;
    localparam int ICB_GATE1_MUL = 10;
    localparam int ICB_GATE2_MUL = 1;
    localparam logic [31:0] ICB_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ICB_ADDR_REF = 32'h0000_0004;
    localparam logic [31:0] ICB_ADDR_COUNT = 32'h0000_0008;
    localparam logic [31:0] ICB_ADDR_FREQ = 32'h0000_000C;
    localparam logic [31:0] ICB_ADDR_FLAGS = 32'h0000_0010;
    localparam logic [31:0] ICB_ADDR_STAT = 32'h0000_0014;
    localparam logic [31:0] ICB_ADDR_MASK = 32'h0000_0018;
    localparam int ICB_CTRL_MODE_LSB = 0;
    localparam int ICB_CTRL_GATE_LSB = 4;
    localparam int ICB_CTRL_SELA_LSB = 8;
    localparam int ICB_CTRL_SELB_LSB = 12;
    localparam int ICB_CTRL_ENGATE_BIT = 16;
    localparam int ICB_CTRL_CLEAR_BIT = 17;
    localparam logic [31:0] ICB_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ICB_REF_RESET = 32'h0000_0000;
    localparam logic [3:0] ICB_MASK_RESET = 4'h0;
    localparam int ICB_STAT_HIT = 0;
    localparam int ICB_STAT_FREQ = 1;
    localparam int ICB_STAT_GATE = 2;
    localparam int ICB_STAT_ERR = 3;
    typedef enum logic [2:0] {
        ICB_MODE_EXTDIR,
        ICB_MODE_DUAL,
        ICB_MODE_QUAD,
        ICB_MODE_FOVER,
        ICB_MODE_FUNDER
    } icb_mode_e;
    typedef struct packed {
        logic [3:0] flags;
        logic signed [31:0] count;
    } icb_out_s;
endpackage

// *** rtl/icb_counter.sv ***
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module icb_counter
    import icb_pkg::*;
#(
    parameter int GATE0_CYC = icb_pkg::ICB_GATE0_CYC,
    parameter int GATE1_CYC = icb_pkg::ICB_GATE1_CYC,
    parameter int GATE2_CYC = icb_pkg::ICB_GATE2_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] input_line,
    input wire logic activate,
    input wire logic count_clear,
    output icb_pkg::icb_out_s counter_value_output,
    output logic irq_pulse,
    output logic irq
);
    import icb_pkg::*;

    logic [31:0] ctrl_reg;
    logic signed [31:0] ref_reg;
    logic [3:0] flags_reg;
    logic [3:0] stat_reg;
    logic [3:0] stat_next;
    logic [3:0] mask_reg;
    logic signed [31:0] count_reg;
    logic signed [31:0] count_next;
    logic [31:0] freq_reg;
    logic [31:0] gate_cnt_reg;
    logic [31:0] edge_cnt_reg;
    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [7:0] s3_reg;
    logic [7:0] lvl_reg;
    logic [7:0] rise;
    logic quad_a_rise_dir_reg;
    logic irq_pulse_reg;
    logic icb_wr;
    logic running;
    logic a_pulse;
    logic a_lvl;
    logic b_lvl;
    logic b_pulse;
    logic gate_end;
    logic freq_hit;
    logic cnt_hit;
    logic [31:0] gate_len;
    logic [31:0] gate_mul;
    logic [31:0] freq_now;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    icb_mode_e mode;

    assign mode = icb_mode_e'(ctrl_reg[ICB_CTRL_MODE_LSB +: 3]);
    assign sel_a = ctrl_reg[ICB_CTRL_SELA_LSB +: 3];
    assign sel_b = ctrl_reg[ICB_CTRL_SELB_LSB +: 3];
    assign icb_wr = psel && penable && pwrite;
    assign pready = 1'b1;

    assign running = !ctrl_reg[ICB_CTRL_ENGATE_BIT] || activate;

    // Input synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            s3_reg <= 8'h00;
            lvl_reg <= 8'h00;
        end
        else
        begin
            s1_reg <= input_line;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
        end
    end

    // Filtered level moves only when both late stages agree.
    assign rise = (s2_reg & s3_reg) & ~lvl_reg;

    // In external-direction mode the pulse uses lines 1-4, direction lines 5-8.
    always_comb
    begin
        if (mode == ICB_MODE_EXTDIR)
        begin
            a_pulse = rise[{1'b0, sel_a[1:0]}];
            a_lvl = lvl_reg[{1'b0, sel_a[1:0]}];
            b_lvl = lvl_reg[{1'b1, sel_b[1:0]}];
            b_pulse = rise[{1'b1, sel_b[1:0]}];
        end
        else
        begin
            a_pulse = rise[sel_a];
            a_lvl = lvl_reg[sel_a];
            b_lvl = lvl_reg[sel_b];
            b_pulse = rise[sel_b];
        end
    end

    // Quadrature direction is latched at each A rising edge from the B level.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quad_a_rise_dir_reg <= 1'b0;
        end
        else
        begin
            if (a_pulse)
            begin
                quad_a_rise_dir_reg <= b_lvl;
            end
        end
    end

    always_comb
    begin
        count_next = count_reg;
        case (mode)
            ICB_MODE_EXTDIR:
            begin
                if (a_pulse)
                begin
                    count_next = b_lvl ? count_reg - 32'sd1 : count_reg + 32'sd1;
                end
            end
            ICB_MODE_DUAL:
            begin
                count_next = count_reg + (a_pulse ? 32'sd1 : 32'sd0)
                    - (b_pulse ? 32'sd1 : 32'sd0);
            end
            ICB_MODE_QUAD:
            begin
                if (a_pulse)
                begin
                    count_next = b_lvl ? count_reg - 32'sd2 : count_reg + 32'sd2;
                end
            end
            default:
            begin
                count_next = count_reg;
            end
        endcase
    end

    // Signed count wraps through the full 32-bit range.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 32'sh0000_0000;
        end
        else if (count_clear || ctrl_reg[ICB_CTRL_CLEAR_BIT])
        begin
            count_reg <= 32'sh0000_0000;
        end
        else if (running)
        begin
            count_reg <= count_next;
        end
    end

    // Hit when the count arrives at the reference.
    assign cnt_hit = running && !count_clear && !ctrl_reg[ICB_CTRL_CLEAR_BIT]
        && (mode == ICB_MODE_EXTDIR || mode == ICB_MODE_DUAL || mode == ICB_MODE_QUAD)
        && count_next != count_reg && count_next == ref_reg;

    always_comb
    begin
        case (ctrl_reg[ICB_CTRL_GATE_LSB +: 2])
            2'h0:
            begin
                gate_len = 32'(GATE0_CYC);
                gate_mul = 32'(ICB_GATE0_MUL);
            end
            2'h1:
            begin
                gate_len = 32'(GATE1_CYC);
                gate_mul = 32'(ICB_GATE1_MUL);
            end
            default:
            begin
                gate_len = 32'(GATE2_CYC);
                gate_mul = 32'(ICB_GATE2_MUL);
            end
        endcase
    end

    assign gate_end = running && (gate_cnt_reg >= gate_len - 32'h0000_0001);
    assign freq_now = 32'((edge_cnt_reg + (a_pulse ? 32'h1 : 32'h0)) * gate_mul);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_cnt_reg <= 32'h0000_0000;
            edge_cnt_reg <= 32'h0000_0000;
            freq_reg <= 32'h0000_0000;
        end
        else if (!running || !(mode == ICB_MODE_FOVER || mode == ICB_MODE_FUNDER))
        begin
            gate_cnt_reg <= 32'h0000_0000;
            edge_cnt_reg <= 32'h0000_0000;
        end
        else if (gate_end)
        begin
            gate_cnt_reg <= 32'h0000_0000;
            edge_cnt_reg <= 32'h0000_0000;
            freq_reg <= freq_now;
        end
        else
        begin
            gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
            edge_cnt_reg <= edge_cnt_reg + (a_pulse ? 32'h1 : 32'h0);
        end
    end

    // Over-frequency and under-frequency compare at each gate end.
    assign freq_hit = gate_end && (
        (mode == ICB_MODE_FOVER && $signed({1'b0, freq_now}) > $signed({ref_reg[31], ref_reg}))
        || (mode == ICB_MODE_FUNDER
            && $signed({1'b0, freq_now}) < $signed({ref_reg[31], ref_reg})));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_pulse_reg <= 1'b0;
        end
        else
        begin
            irq_pulse_reg <= cnt_hit || freq_hit;
        end
    end
    assign irq_pulse = irq_pulse_reg;

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    always_comb
    begin
        stat_next = stat_reg;
        if (icb_wr && paddr == ICB_ADDR_STAT)
        begin
            stat_next = stat_reg & ~pwdata[3:0];
        end
        stat_next[ICB_STAT_HIT] = stat_next[ICB_STAT_HIT] | cnt_hit;
        stat_next[ICB_STAT_FREQ] = stat_next[ICB_STAT_FREQ] | freq_hit;
        stat_next[ICB_STAT_GATE] = stat_next[ICB_STAT_GATE] | gate_end;
        stat_next[ICB_STAT_ERR] = stat_next[ICB_STAT_ERR]
            | (psel && penable && pslverr);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_reg <= 4'h0;
        end
        else
        begin
            stat_reg <= stat_next;
        end
    end
    assign irq = |(stat_reg & mask_reg);

    // Software registers; the handler writes the four flags.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= ICB_CTRL_RESET;
            ref_reg <= ICB_REF_RESET;
            mask_reg <= ICB_MASK_RESET;
            flags_reg <= 4'h0;
        end
        else if (icb_wr)
        begin
            case (paddr)
                ICB_ADDR_CTRL: ctrl_reg <= pwdata;
                ICB_ADDR_REF: ref_reg <= pwdata;
                ICB_ADDR_MASK: mask_reg <= pwdata[3:0];
                ICB_ADDR_FLAGS: flags_reg <= pwdata[3:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    assign counter_value_output.flags = flags_reg;
    assign counter_value_output.count = count_reg;

    always_comb
    begin
        pslverr = 1'b0;
        case (paddr)
            ICB_ADDR_CTRL: prdata = ctrl_reg;
            ICB_ADDR_REF: prdata = ref_reg;
            ICB_ADDR_COUNT: prdata = count_reg;
            ICB_ADDR_FREQ: prdata = freq_reg;
            ICB_ADDR_FLAGS: prdata = {28'h0000000, flags_reg};
            ICB_ADDR_STAT: prdata = {28'h0000000, stat_reg};
            ICB_ADDR_MASK: prdata = {28'h0000000, mask_reg};
            default:
            begin
                prdata = 32'h0000_0000;
                pslverr = psel;
            end
        endcase
    end

    // Assertions.
    clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        count_clear |=> count_reg == 32'sh0) else $error("count not cleared");
    hit_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_hit |=> irq_pulse && stat_reg[ICB_STAT_HIT]) else $error("hit lost");
    rise_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rise & ~($past(input_line, 2) & $past(input_line, 3))) == 8'h00)
        else $error("edge before sync");
    ext_up_a: assert property (@(posedge clk) disable iff (!rst_n)
        running && mode == ICB_MODE_EXTDIR && a_pulse && !b_lvl && !count_clear
        && !ctrl_reg[ICB_CTRL_CLEAR_BIT] |=> count_reg == $past(count_reg) + 32'sd1)
        else $error("ext up wrong");
    quad_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        running && mode == ICB_MODE_QUAD && a_pulse && !count_clear
        && !ctrl_reg[ICB_CTRL_CLEAR_BIT] |=> count_reg - $past(count_reg) == 32'sd2
        || $past(count_reg) - count_reg == 32'sd2) else $error("quad step wrong");
    quad_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        running && mode == ICB_MODE_QUAD && a_pulse && !count_clear
        && !ctrl_reg[ICB_CTRL_CLEAR_BIT]
        |=> quad_a_rise_dir_reg == ($past(count_reg) - count_reg == 32'sd2))
        else $error("quad dir wrong");
    hold_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !running && !count_clear && !ctrl_reg[ICB_CTRL_CLEAR_BIT]
        |=> $stable(count_reg)) else $error("counted while off");
    freq_over_a: assert property (@(posedge clk) disable iff (!rst_n)
        gate_end && mode == ICB_MODE_FOVER && !ref_reg[31] && freq_now > ref_reg
        |=> irq_pulse) else $error("over missed");
    freq_under_a: assert property (@(posedge clk) disable iff (!rst_n)
        gate_end && mode == ICB_MODE_FUNDER && !ref_reg[31] && freq_now < ref_reg
        |=> irq_pulse) else $error("under missed");
    dual_a: assert property (@(posedge clk) disable iff (!rst_n)
        running && mode == ICB_MODE_DUAL && a_pulse && !b_pulse && !count_clear
        && !ctrl_reg[ICB_CTRL_CLEAR_BIT] |=> count_reg == $past(count_reg) + 32'sd1)
        else $error("dual wrong");
endmodule

// *** dv/icb_src.sv ***
`timescale 1ns/1ps
module icb_src
(
    input wire logic clk,
    output logic [7:0] input_line
);
    initial input_line = 8'h00;
    task automatic set(input int ln, input logic v);
        @(posedge clk);
        input_line[ln] <= v;
    endtask
    task automatic pulse(input int ln, input int n, input int h);
        repeat (n)
        begin
            set(ln, 1'b1);
            repeat (h) @(posedge clk);
            set(ln, 1'b0);
            repeat (h) @(posedge clk);
        end
    endtask
    task automatic quad(input int a, input int b, input int n, input bit rev);
        repeat (n)
        begin
            set(rev ? b : a, 1'b1);
            repeat (6) @(posedge clk);
            set(rev ? a : b, 1'b1);
            repeat (6) @(posedge clk);
            set(rev ? b : a, 1'b0);
            repeat (6) @(posedge clk);
            set(rev ? a : b, 1'b0);
            repeat (6) @(posedge clk);
        end
    endtask
endmodule

// *** dv/interrupt_counter_block_tb.sv ***
`timescale 1ns/1ps
module interrupt_counter_block_tb;
    import icb_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] input_line;
    logic activate = 1'b1;
    logic count_clear = 1'b0;
    icb_out_s cvo;
    logic irq_pulse;
    logic irq;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_pulse = 0;
    int n0;
    int seed = 32'h7163;
    logic [63:0] expq[$];
    logic [63:0] e;
    logic [31:0] rv;
    logic [31:0] fref[4] = '{32'h0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0};
    logic [31:0] fexp[3] = '{32'd1000, 32'd200, 32'd40};
    always #12.5 clk = ~clk;
    icb_counter #(.GATE0_CYC(100), .GATE1_CYC(200), .GATE2_CYC(400)) icb_counter_i
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .input_line(input_line), .activate(activate),
        .count_clear(count_clear), .counter_value_output(cvo),
        .irq_pulse(irq_pulse), .irq(irq)
    );
    icb_src icb_src_i (.clk(clk), .input_line(input_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m);
        expq.push_back({m, x});
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] cfg(input int md, input int g, input int a, input int b,
        input int en);
        return 32'((md << ICB_CTRL_MODE_LSB) | (g << ICB_CTRL_GATE_LSB)
            | (a << ICB_CTRL_SELA_LSB) | (b << ICB_CTRL_SELB_LSB)
            | (en << ICB_CTRL_ENGATE_BIT));
    endfunction
    task automatic zero();
        @(posedge clk);
        count_clear <= 1'b1;
        repeat (2) @(posedge clk);
        count_clear <= 1'b0;
        apb(1'b1, ICB_ADDR_STAT, 32'hF);
    endtask
    task automatic cnt(input logic [31:0] x);
        repeat (8) @(posedge clk);
        check(cvo.count, x);
        rd(ICB_ADDR_COUNT, x, ALL);
    endtask
    // Read results are compared in the cycle that the access completes.
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
            check(32'(pslverr), 32'(paddr > ICB_ADDR_MASK));
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
        begin
            e = expq.pop_front();
            check(prdata & e[63:32], e[31:0]);
        end
        if (irq_pulse === 1'b1)
            n_pulse++;
    end
    initial
    begin
        #1000000;
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(ICB_ADDR_CTRL, ICB_CTRL_RESET, ALL);
        rd(ICB_ADDR_REF, ICB_REF_RESET, ALL);
        rd(ICB_ADDR_MASK, {28'h0, ICB_MASK_RESET}, 32'hF);
        rd(32'h0000_0040, 32'h0, ALL);
        rd(ICB_ADDR_STAT, 32'h8, 32'h8);
        apb(1'b1, ICB_ADDR_CTRL, cfg(0, 0, 5, 2, 0));
        zero();
        icb_src_i.pulse(1, 3, 6);
        cnt(32'h3);
        icb_src_i.set(6, 1'b1);
        icb_src_i.pulse(1, 2, 6);
        cnt(32'h1);
        icb_src_i.set(6, 1'b0);
        apb(1'b1, ICB_ADDR_CTRL, cfg(1, 0, 2, 3, 0));
        zero();
        icb_src_i.pulse(2, 3, 6);
        icb_src_i.pulse(3, 1, 6);
        cnt(32'h2);
        apb(1'b1, ICB_ADDR_CTRL, cfg(2, 0, 0, 1, 0));
        zero();
        icb_src_i.quad(0, 1, 2, 1'b0);
        cnt(32'h4);
        icb_src_i.quad(0, 1, 3, 1'b1);
        cnt(32'hFFFF_FFFE);
        apb(1'b1, ICB_ADDR_CTRL, cfg(2, 0, 0, 1, 0) | 32'h0002_0000);
        cnt(32'h0);
        zero();
        cnt(32'h0);
        apb(1'b1, ICB_ADDR_CTRL, cfg(0, 0, 0, 0, 0));
        apb(1'b1, ICB_ADDR_REF, 32'h2);
        apb(1'b1, ICB_ADDR_MASK, 32'h1);
        zero();
        n0 = n_pulse;
        icb_src_i.pulse(0, 3, 6);
        cnt(32'h3);
        check(32'(n_pulse - n0), 32'h1);
        check(32'(irq), 32'h1);
        rd(ICB_ADDR_STAT, 32'h1, 32'h1);
        apb(1'b1, ICB_ADDR_STAT, 32'h1);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0);
        apb(1'b1, ICB_ADDR_CTRL, cfg(0, 0, 0, 0, 1));
        zero();
        activate <= 1'b0;
        icb_src_i.pulse(0, 3, 6);
        cnt(32'h0);
        activate <= 1'b1;
        icb_src_i.pulse(0, 2, 6);
        cnt(32'h2);
        for (int g = 0; g < 3; g++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                apb(1'b1, ICB_ADDR_CTRL, cfg(3 + m % 2, g, 0, 0, 0));
                apb(1'b1, ICB_ADDR_REF, fref[m]);
                apb(1'b1, ICB_ADDR_STAT, 32'hF);
                icb_src_i.pulse(0, (100 << g) / 4, 6);
                rd(ICB_ADDR_STAT, (m < 2) ? 32'h2 : 32'h0, 32'h2);
            end
            // A pulse period that divides every gate gives an exact edge count per gate.
            apb(1'b1, ICB_ADDR_CTRL, cfg(3, g, 0, 0, 0));
            fork
                icb_src_i.pulse(0, (100 << g) * 6 / 10, 4);
                begin
                    repeat ((100 << g) * 4) @(posedge clk);
                    rd(ICB_ADDR_FREQ, fexp[g], ALL);
                end
            join
        end
        repeat (4)
        begin
            rv = $random(seed);
            apb(1'b1, ICB_ADDR_REF, rv);
            rd(ICB_ADDR_REF, rv, ALL);
            apb(1'b1, ICB_ADDR_FLAGS, rv & 32'hF);
            repeat (2) @(posedge clk);
            check(32'(cvo.flags), rv & 32'hF);
        end
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule
